// >>> hdl/dac_mode_regs.sv
// mode-control registers, serial control port and soft-mute attenuator ramp
`timescale 1ns/1ns
// Summary of operation
// - three-bit format field selects serial audio format, reset 24-bit I2S
// - two-bit field picks de-emphasis rate; in bitstream mode picks analog FIR performance
// - de-emphasis applied to both channels only while enable bit is one
// - soft mute ramps both channels to mute through a 256-step attenuator
// - attenuator steps once per 1, 2, 4 or 8 word clock periods
// - phase bit one inverts output polarity of both channels
// - output disable forces both outputs to bipolar zero regardless of data
// - rolloff bit selects sharp response at zero, slow response at one
// - zero-detect mute holds muted outputs at bipolar zero when both channels zero
// - zero-detect mute has no effect in bitstream mode
// - writing one to write-only reset bit makes one reset pulse, restores defaults
// - bitstream bit switches audio input interface to bitstream format
// - filter bypass bit bypasses internal interpolation filter for external filter
// - mono bit runs both converters balanced on one input channel
// - channel select picks left or right mono source, only in mono mode
// - bitstream mono takes its stream from the main data input pin
// - oversampling field sets modulator rate 64, 32 or 128 times; 11 reserved
// - in bitstream mode oversampling field selects analog FIR bit clock speed
// - control word top bit selects write at zero, read at one
module dac_mode_regs
   import dac_mode_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       ctrl_sel_n,
   input  wire logic       ctrl_clk,
   input  wire logic       ctrl_din,
   output logic            ctrl_dout,
   output logic            ctrl_dout_oe,
   input  wire logic       word_clock,
   input  wire logic       zero_left,
   input  wire logic       zero_right,
   output mode_ctrl_t      mode_q,
   output path_ctrl_t      path_q,
   output logic [7:0]      attn_level_q,
   output logic            soft_reset_pulse
);

   // pin synchronisers; first stage feeds only the second
   logic [1:0] sel_sync_q;
   logic [1:0] clk_sync_q;
   logic [1:0] din_sync_q;
   logic [1:0] wck_sync_q;
   logic       clk_last_q;
   logic       wck_last_q;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_sync_q <= 2'h3;
         clk_sync_q <= 2'h0;
         din_sync_q <= 2'h0;
         wck_sync_q <= 2'h0;
         clk_last_q <= 1'h0;
         wck_last_q <= 1'h0;
      end
      else
      begin
         sel_sync_q <= {sel_sync_q[0], ctrl_sel_n};
         clk_sync_q <= {clk_sync_q[0], ctrl_clk};
         din_sync_q <= {din_sync_q[0], ctrl_din};
         wck_sync_q <= {wck_sync_q[0], word_clock};
         clk_last_q <= clk_sync_q[1];
         wck_last_q <= wck_sync_q[1];
      end
   end

   logic in_frame;
   logic clk_rise;
   logic clk_fall;
   logic wck_rise;

   assign in_frame = ~sel_sync_q[1];
   assign clk_rise = in_frame & clk_sync_q[1] & ~clk_last_q;
   assign clk_fall = in_frame & ~clk_sync_q[1] & clk_last_q;
   assign wck_rise = wck_sync_q[1] & ~wck_last_q;

   // serial frame receiver
   logic [4:0]  bit_cnt_q;
   logic [15:0] shift_in_q;
   logic [15:0] word_d;
   logic        head_done;
   logic        word_done;

   assign word_d    = {shift_in_q[14:0], din_sync_q[1]};
   assign head_done = clk_rise && (bit_cnt_q == 5'(HEAD_BITS - 1));
   assign word_done = clk_rise && (bit_cnt_q == 5'(FRAME_BITS - 1));

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bit_cnt_q  <= 5'h00;
         shift_in_q <= 16'h0000;
      end
      else if (!in_frame)
      begin
         bit_cnt_q  <= 5'h00;
         shift_in_q <= 16'h0000;
      end
      else if (clk_rise)
      begin
         // bits past the sixteenth are ignored
         if (bit_cnt_q != 5'(FRAME_BITS))
            bit_cnt_q <= bit_cnt_q + 5'h01;
         shift_in_q <= word_d;
      end
   end

   // readback image of one register
   function automatic logic [7:0] read_image(input logic [6:0] idx, input mode_ctrl_t m);
      logic [7:0] r;
      r = 8'h00;
      unique case (idx)
         IDX_FMT_EMPH:
         begin
            r[FORMAT_LSB +: 3]    = m.audio_format_sel;
            r[EMPH_RATE_LSB +: 2] = m.deemph_rate_sel;
            r[EMPH_EN_BIT]        = m.deemph_enable;
            r[MUTE_BIT]           = m.soft_mute;
         end
         IDX_OUT_RAMP:
         begin
            r[INVERT_BIT]         = m.phase_invert;
            r[RAMP_RATE_LSB +: 2] = m.ramp_rate_sel;
            r[OUT_OFF_BIT]        = m.output_disable;
            r[ROLLOFF_BIT]        = m.rolloff_sel;
            r[ZERO_HOLD_BIT]      = m.zero_hold_mute_en;
         end
         IDX_IF_MODE:
         begin
            // reset bit is write-only and reads zero
            r[STREAM_BIT]        = m.bitstream_mode_en;
            r[BYPASS_BIT]        = m.filter_bypass_en;
            r[MONO_BIT]          = m.mono_en;
            r[MONO_SRC_BIT]      = m.mono_source_sel;
            r[MOD_RATE_LSB +: 2] = m.modulator_rate_sel;
         end
         IDX_ZERO_OUT:
         begin
            r[STREAM_ZERO_LSB +: 2] = m.bitstream_zero_flag_sel;
            r[SAMPLE_ZERO_BIT]      = m.sample_zero_flag_en;
         end
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // readback driver: data shifts out on falling edges after the index byte
   logic [7:0] shift_out_q;
   logic       reading_q;
   logic [7:0] rd_image;

   assign rd_image = read_image(word_d[6:0], mode_q);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         shift_out_q  <= 8'h00;
         reading_q    <= 1'h0;
         ctrl_dout    <= 1'h0;
         ctrl_dout_oe <= 1'h0;
      end
      else if (!in_frame || word_done)
      begin
         reading_q    <= 1'h0;
         ctrl_dout    <= 1'h0;
         ctrl_dout_oe <= 1'h0;
      end
      else if (head_done && word_d[7])
      begin
         shift_out_q  <= rd_image;
         reading_q    <= 1'h1;
         ctrl_dout    <= rd_image[7];
         ctrl_dout_oe <= 1'h1;
      end
      else if (reading_q && clk_fall && bit_cnt_q > 5'(HEAD_BITS))
      begin
         shift_out_q <= {shift_out_q[6:0], 1'h0};
         ctrl_dout   <= shift_out_q[6];
      end
   end

   // register file; a reset-bit write restores every field
   logic       write_hit;
   logic [6:0] wr_idx;
   logic [7:0] wr_data;

   assign wr_idx    = shift_in_q[IDX_MSB-1 -: 7];
   assign wr_data   = word_d[7:0];
   assign write_hit = word_done && !shift_in_q[RW_BIT-1];

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_q           <= MODE_RST;
         soft_reset_pulse <= 1'h0;
      end
      else
      begin
         soft_reset_pulse <= 1'h0;
         if (write_hit)
         begin
            unique case (wr_idx)
               IDX_FMT_EMPH:
               begin
                  mode_q.audio_format_sel <= wr_data[FORMAT_LSB +: 3];
                  mode_q.deemph_rate_sel  <= wr_data[EMPH_RATE_LSB +: 2];
                  mode_q.deemph_enable    <= wr_data[EMPH_EN_BIT];
                  mode_q.soft_mute        <= wr_data[MUTE_BIT];
               end
               IDX_OUT_RAMP:
               begin
                  mode_q.phase_invert      <= wr_data[INVERT_BIT];
                  mode_q.ramp_rate_sel     <= wr_data[RAMP_RATE_LSB +: 2];
                  mode_q.output_disable    <= wr_data[OUT_OFF_BIT];
                  mode_q.rolloff_sel       <= wr_data[ROLLOFF_BIT];
                  mode_q.zero_hold_mute_en <= wr_data[ZERO_HOLD_BIT];
               end
               IDX_IF_MODE:
               begin
                  if (wr_data[SOFT_RST_BIT])
                  begin
                     mode_q           <= MODE_RST;
                     soft_reset_pulse <= 1'h1;
                  end
                  else
                  begin
                     mode_q.bitstream_mode_en  <= wr_data[STREAM_BIT];
                     mode_q.filter_bypass_en   <= wr_data[BYPASS_BIT];
                     mode_q.mono_en            <= wr_data[MONO_BIT];
                     mode_q.mono_source_sel    <= wr_data[MONO_SRC_BIT];
                     mode_q.modulator_rate_sel <= wr_data[MOD_RATE_LSB +: 2];
                  end
               end
               IDX_ZERO_OUT:
               begin
                  mode_q.bitstream_zero_flag_sel <= wr_data[STREAM_ZERO_LSB +: 2];
                  mode_q.sample_zero_flag_en     <= wr_data[SAMPLE_ZERO_BIT];
               end
               default:
               begin
                  // unmapped index: ignored
               end
            endcase
         end
      end
   end

   // attenuator ramp, paced by word clock periods
   logic [2:0] pace_cnt_q;
   logic [2:0] pace_last;
   logic       step_tick;
   logic [7:0] attn_target;

   assign pace_last   = 3'((4'h1 << mode_q.ramp_rate_sel) - 4'h1);
   assign step_tick   = wck_rise && (pace_cnt_q >= pace_last);
   assign attn_target = mode_q.soft_mute ? ATTN_MUTE : ATTN_FULL;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         pace_cnt_q <= 3'h0;
      else if (soft_reset_pulse || step_tick)
         pace_cnt_q <= 3'h0;
      else if (wck_rise)
         pace_cnt_q <= pace_cnt_q + 3'h1;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         attn_level_q <= ATTN_FULL;
      else if (soft_reset_pulse)
         attn_level_q <= ATTN_FULL;
      else if (step_tick && attn_level_q > attn_target)
         attn_level_q <= attn_level_q - 8'h01;
      else if (step_tick && attn_level_q < attn_target)
         attn_level_q <= attn_level_q + 8'h01;
   end

   // settings as applied by the datapath
   logic zero_hold;
   assign zero_hold = mode_q.zero_hold_mute_en && zero_left && zero_right
                      && !mode_q.bitstream_mode_en;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         path_q <= '0;
      else
      begin
         path_q.deemph_active <= mode_q.deemph_enable && !mode_q.bitstream_mode_en;
         path_q.deemph_rate   <= mode_q.bitstream_mode_en ? 2'h0 : mode_q.deemph_rate_sel;
         path_q.fir_perf_sel  <= mode_q.bitstream_mode_en ? mode_q.deemph_rate_sel
                                                          : 2'h0;
         path_q.zero_level_force <= mode_q.output_disable || zero_hold;
         path_q.mono_active   <= mode_q.mono_en;
         path_q.mono_right    <= mode_q.mono_en && mode_q.mono_source_sel;
         path_q.bitstream_main_input <= mode_q.mono_en && mode_q.bitstream_mode_en;
         // reserved rate code leaves the modulator at its default rate
         path_q.modulator_rate <= (mode_q.bitstream_mode_en
                                   || mode_q.modulator_rate_sel == 2'h3)
                                  ? 2'h0 : mode_q.modulator_rate_sel;
         path_q.bitstream_clk_sel <= mode_q.bitstream_mode_en
                                     ? mode_q.modulator_rate_sel : 2'h0;
         path_q.mute_reached <= mode_q.soft_mute && attn_level_q == ATTN_MUTE;
      end
   end

   // checks
   property p_soft_reset_pulse_restores;
      @(posedge clock) disable iff (sys_rst)
      write_hit && wr_idx == IDX_IF_MODE && wr_data[SOFT_RST_BIT]
      |=> soft_reset_pulse && mode_q == MODE_RST ##1 !soft_reset_pulse;
   endproperty
   a_soft_reset_pulse_restores: assert property (p_soft_reset_pulse_restores)
      else $error("soft reset did not restore defaults in one pulse");

   property p_attn_moves_on_tick;
      @(posedge clock) disable iff (sys_rst)
      // a soft reset also returns the level to full scale
      $changed(attn_level_q) |-> $past(step_tick) || $past(soft_reset_pulse);
   endproperty
   a_attn_moves_on_tick: assert property (p_attn_moves_on_tick)
      else $error("attenuator moved without a pace tick");

   property p_mute_ramps_down;
      @(posedge clock) disable iff (sys_rst)
      step_tick && mode_q.soft_mute && attn_level_q != ATTN_MUTE && !soft_reset_pulse
      |=> attn_level_q == $past(attn_level_q) - 8'h01;
   endproperty
   a_mute_ramps_down: assert property (p_mute_ramps_down)
      else $error("soft mute did not step the attenuator down");

   property p_pace_ts;
      @(posedge clock) disable iff (sys_rst)
      wck_rise && !step_tick && !soft_reset_pulse |=> pace_cnt_q == $past(pace_cnt_q) + 3'h1;
   endproperty
   a_pace_ts: assert property (p_pace_ts)
      else $error("pace counter missed a word clock period");

   property p_disable_forces_zero;
      @(posedge clock) disable iff (sys_rst)
      mode_q.output_disable |=> path_q.zero_level_force;
   endproperty
   a_disable_forces_zero: assert property (p_disable_forces_zero)
      else $error("output disable did not force bipolar zero");

   property p_no_zero_hold_bitstream;
      @(posedge clock) disable iff (sys_rst)
      mode_q.bitstream_mode_en && !mode_q.output_disable |=> !path_q.zero_level_force;
   endproperty
   a_no_zero_hold_bitstream: assert property (p_no_zero_hold_bitstream)
      else $error("zero-detect mute acted in bitstream mode");

   property p_zero_hold;
      @(posedge clock) disable iff (sys_rst)
      zero_hold |=> path_q.zero_level_force;
   endproperty
   a_zero_hold: assert property (p_zero_hold)
      else $error("zero condition did not hold bipolar zero");

   property p_source_only_mono;
      @(posedge clock) disable iff (sys_rst)
      !mode_q.mono_en |=> !path_q.mono_right && !path_q.bitstream_main_input;
   endproperty
   a_source_only_mono: assert property (p_source_only_mono)
      else $error("mono source applied outside mono mode");

   property p_read_drives;
      @(posedge clock) disable iff (sys_rst)
      head_done && word_d[7] |=> ctrl_dout_oe;
   endproperty
   a_read_drives: assert property (p_read_drives)
      else $error("read request did not drive the data line");

   property p_write_no_drive;
      @(posedge clock) disable iff (sys_rst)
      head_done && !word_d[7] |=> !ctrl_dout_oe;
   endproperty
   a_write_no_drive: assert property (p_write_no_drive)
      else $error("write request drove the data line");

   c_mute_done:  cover property (@(posedge clock) disable iff (sys_rst)
                                 path_q.mute_reached);
   c_read:       cover property (@(posedge clock) disable iff (sys_rst)
                                 ctrl_dout_oe && word_done);
   c_soft_reset: cover property (@(posedge clock) disable iff (sys_rst)
                                 soft_reset_pulse);
   c_slow_ramp:  cover property (@(posedge clock) disable iff (sys_rst)
                                 step_tick && mode_q.ramp_rate_sel == 2'h3);

endmodule // dac_mode_regs

// >>> hdl/dac_mode_pkg.sv
// constants and carrier types for the audio converter mode-control registers
package dac_mode_pkg;

   // control word layout
   localparam int          FRAME_BITS = 16;
   localparam int          HEAD_BITS  = 8;
   localparam int          RW_BIT     = 15;
   localparam int          IDX_MSB    = 14;
   localparam int          IDX_LSB    = 8;

   // register indices
   localparam logic [6:0]  IDX_FMT_EMPH = 7'h12;
   localparam logic [6:0]  IDX_OUT_RAMP = 7'h13;
   localparam logic [6:0]  IDX_IF_MODE  = 7'h14;
   localparam logic [6:0]  IDX_ZERO_OUT = 7'h15;

   // format_and_emphasis_control fields
   localparam int          FORMAT_LSB      = 4;
   localparam int          EMPH_RATE_LSB   = 2;
   localparam int          EMPH_EN_BIT     = 1;
   localparam int          MUTE_BIT        = 0;
   // output_and_ramp_control fields
   localparam int          INVERT_BIT      = 7;
   localparam int          RAMP_RATE_LSB   = 5;
   localparam int          OUT_OFF_BIT     = 4;
   localparam int          ROLLOFF_BIT     = 1;
   localparam int          ZERO_HOLD_BIT   = 0;
   // interface_mode_control fields
   localparam int          SOFT_RST_BIT    = 6;
   localparam int          STREAM_BIT      = 5;
   localparam int          BYPASS_BIT      = 4;
   localparam int          MONO_BIT        = 3;
   localparam int          MONO_SRC_BIT    = 2;
   localparam int          MOD_RATE_LSB    = 0;
   // zero_output_control fields
   localparam int          STREAM_ZERO_LSB = 1;
   localparam int          SAMPLE_ZERO_BIT = 0;

   // attenuator end points
   localparam logic [7:0]  ATTN_FULL = 8'hff;
   localparam logic [7:0]  ATTN_MUTE = 8'h00;

   typedef struct packed {
      logic [2:0] audio_format_sel;
      logic [1:0] deemph_rate_sel;
      logic       deemph_enable;
      logic       soft_mute;
      logic       phase_invert;
      logic [1:0] ramp_rate_sel;
      logic       output_disable;
      logic       rolloff_sel;
      logic       zero_hold_mute_en;
      logic       bitstream_mode_en;
      logic       filter_bypass_en;
      logic       mono_en;
      logic       mono_source_sel;
      logic [1:0] modulator_rate_sel;
      logic [1:0] bitstream_zero_flag_sel;
      logic       sample_zero_flag_en;
   } mode_ctrl_t;

   localparam mode_ctrl_t MODE_RST = '{
      audio_format_sel:        3'h5,
      deemph_rate_sel:         2'h0,
      deemph_enable:           1'h0,
      soft_mute:               1'h0,
      phase_invert:            1'h0,
      ramp_rate_sel:           2'h0,
      output_disable:          1'h0,
      rolloff_sel:             1'h0,
      zero_hold_mute_en:       1'h0,
      bitstream_mode_en:       1'h0,
      filter_bypass_en:        1'h0,
      mono_en:                 1'h0,
      mono_source_sel:         1'h0,
      modulator_rate_sel:      2'h0,
      bitstream_zero_flag_sel: 2'h0,
      sample_zero_flag_en:     1'h1
   };

   // settings as the datapath should apply them
   typedef struct packed {
      logic       deemph_active;
      logic [1:0] deemph_rate;
      logic [1:0] fir_perf_sel;
      logic       zero_level_force;
      logic       mono_active;
      logic       mono_right;
      logic       bitstream_main_input;
      logic [1:0] modulator_rate;
      logic [1:0] bitstream_clk_sel;
      logic       mute_reached;
   } path_ctrl_t;

endpackage

// >>> tb/ctrl_host.sv
// host model that drives the serial control port of the mode registers
`timescale 1ns/1ns
module ctrl_host
(
   input  wire logic clock,
   output logic      ctrl_sel_n,
   output logic      ctrl_clk,
   output logic      ctrl_din,
   input  wire logic sdo_line
);
   initial
   begin
      ctrl_sel_n = 1'b1;
      ctrl_clk = 1'b0;
      ctrl_din = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask

   // one frame msb first; fewer than 16 bits leaves the frame unfinished
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      ctrl_sel_n = 1'b0;
      for (int i = 15; i >= 16 - nbits; i--)
      begin
         ctrl_din = word[i];
         // 5 cycles per level, above the 4-cycle minimum of the sync
         tick(5);
         if (i < 8)
            rd[i] = sdo_line;
         ctrl_clk = 1'b1;
         tick(5);
         ctrl_clk = 1'b0;
      end
      tick(5);
      ctrl_sel_n = 1'b1;
      // line left at the inverse of the last data bit between frames
      ctrl_din = ~ctrl_din;
      tick(4);
   endtask
endmodule // ctrl_host

// >>> tb/testbench.sv
// self-checking bench for the mode-control register block
`timescale 1ns/1ns
module testbench;
   import dac_mode_pkg::*;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic       ctrl_sel_n;
   logic       ctrl_clk;
   logic       ctrl_din;
   logic       ctrl_dout;
   logic       ctrl_dout_oe;
   logic       sdo_line;
   logic       word_clock = 1'b0;
   logic       zero_left = 1'b0;
   logic       zero_right = 1'b0;
   mode_ctrl_t mode_q;
   path_ctrl_t path_q;
   logic [7:0] attn_level_q;
   logic       soft_reset_pulse;
   int         num_errors = 0;
   int         cmp_count = 0;
   int         cycles = 0;
   int         wc_half = 4;
   int         wc_cnt = 0;
   int         wc_rises = 0;
   int         pulses = 0;

   // readback line assumed pulled up while the device lets go
   assign sdo_line = ctrl_dout_oe ? ctrl_dout : 1'b1;

   dac_mode_regs dut_u (.clock(clock), .sys_rst(sys_rst), .ctrl_sel_n(ctrl_sel_n),
      .ctrl_clk(ctrl_clk), .ctrl_din(ctrl_din), .ctrl_dout(ctrl_dout),
      .ctrl_dout_oe(ctrl_dout_oe), .word_clock(word_clock), .zero_left(zero_left),
      .zero_right(zero_right), .mode_q(mode_q), .path_q(path_q),
      .attn_level_q(attn_level_q), .soft_reset_pulse(soft_reset_pulse));

   ctrl_host host_u (.clock(clock), .ctrl_sel_n(ctrl_sel_n), .ctrl_clk(ctrl_clk),
      .ctrl_din(ctrl_din), .sdo_line(sdo_line));

   always #50 clock = ~clock;

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      wc_cnt <= (wc_cnt >= wc_half - 1) ? 0 : wc_cnt + 1;
      if (wc_cnt >= wc_half - 1)
      begin
         word_clock <= #10 ~word_clock;
         wc_rises <= wc_rises + int'(!word_clock);
      end
      if (soft_reset_pulse === 1'b1)
         pulses <= pulses + 1;
      if (cycles == 60000)
      begin
         num_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask

   task automatic wr(input logic [6:0] idx, input logic [7:0] data);
      logic [7:0] d;
      host_u.xfer({1'b0, idx, data}, 16, d);
   endtask

   task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      host_u.xfer({1'b1, idx, 8'h00}, 16, d);
      check(32'(d), 32'(exp));
   endtask

   task automatic wait_attn_step();
      logic [7:0] l;
      l = attn_level_q;
      for (int i = 0; i < 3000 && attn_level_q === l; i++)
         tick(1);
   endtask

   task automatic t_defaults();
      logic [7:0] d;
      check(32'(mode_q), 32'(MODE_RST));
      check(32'(path_q), 32'h0);
      check(32'(attn_level_q), 32'hff);
      rd_chk(IDX_FMT_EMPH, 8'h50);
      rd_chk(IDX_OUT_RAMP, 8'h00);
      rd_chk(IDX_IF_MODE, 8'h00);
      rd_chk(IDX_ZERO_OUT, 8'h01);
      wr(7'h10, 8'hff);
      host_u.xfer({1'b0, IDX_ZERO_OUT, 8'h06}, 8, d);
      check(32'(mode_q), 32'(MODE_RST));
      rd_chk(7'h20, 8'h00);
   endtask

   task automatic t_fields();
      wr(IDX_OUT_RAMP, 8'hff);
      rd_chk(IDX_OUT_RAMP, 8'hf3);
      check(32'({mode_q.phase_invert, mode_q.rolloff_sel}), 32'h3);
      check(32'(path_q.zero_level_force), 32'h1);
      wr(IDX_OUT_RAMP, 8'h00);
      check(32'(path_q.zero_level_force), 32'h0);
      wr(IDX_IF_MODE, 8'h30);
      rd_chk(IDX_IF_MODE, 8'h30);
      wr(IDX_ZERO_OUT, 8'hff);
      rd_chk(IDX_ZERO_OUT, 8'h07);
      for (int f = 0; f < 8; f++)
      begin
         wr(IDX_FMT_EMPH, {1'b0, 3'(f), 4'h0});
         rd_chk(IDX_FMT_EMPH, {1'b0, 3'(f), 4'h0});
      end
      // slow word clock keeps 128x legal for the host
      wc_half = 130;
      for (int r = 0; r < 4; r++)
      begin
         wr(IDX_IF_MODE, {6'h0, 2'(r)});
         check(32'(path_q.modulator_rate), (r == 3) ? 32'h0 : 32'(r));
      end
      wc_half = 4;
   endtask

   task automatic t_modes();
      wr(IDX_FMT_EMPH, 8'h5e);
      check(32'({path_q.deemph_active, path_q.deemph_rate}), 32'h7);
      wr(IDX_OUT_RAMP, 8'h01);
      zero_left = 1'b1;
      zero_right = 1'b1;
      wr(IDX_IF_MODE, 8'h2f);
      check(32'({path_q.deemph_active, path_q.fir_perf_sel}), 32'h3);
      check(32'({path_q.bitstream_main_input, path_q.zero_level_force}), 32'h2);
      check(32'(path_q.bitstream_clk_sel), 32'h3);
      wr(IDX_IF_MODE, 8'h0c);
      check(32'({path_q.mono_active, path_q.mono_right, path_q.zero_level_force}), 32'h7);
      wr(IDX_IF_MODE, 8'h04);
      zero_left = 1'b0;
      tick(3);
      check(32'({path_q.mono_active, path_q.mono_right, path_q.zero_level_force}), 32'h0);
   endtask

   task automatic t_ramp();
      int n0;
      wr(IDX_FMT_EMPH, 8'h51);
      for (int r = 0; r < 4; r++)
      begin
         wr(IDX_OUT_RAMP, {1'b0, 2'(r), 5'h0});
         wait_attn_step();
         n0 = wc_rises;
         wait_attn_step();
         check(32'(wc_rises - n0), 32'(1 << r));
      end
      wr(IDX_OUT_RAMP, 8'h00);
      for (int i = 0; i < 4000 && attn_level_q !== 8'h00; i++)
         tick(1);
      tick(2);
      check(32'({attn_level_q, path_q.mute_reached}), 32'h001);
   endtask

   task automatic t_soft_reset();
      int p0;
      p0 = pulses;
      wr(IDX_IF_MODE, 8'h7f);
      check(32'(pulses - p0), 32'h1);
      check(32'(mode_q), 32'(MODE_RST));
      check(32'(attn_level_q), 32'hff);
      rd_chk(IDX_IF_MODE, 8'h00);
   endtask

   initial
   begin
      repeat (6) @(posedge clock);
      #10;
      sys_rst = 1'b0;
      tick(4);
      t_defaults();
      t_fields();
      t_modes();
      t_ramp();
      t_soft_reset();
      close_out();
   end
endmodule // testbench
